// *** verilog/peiu_pkg.sv ***
// Package of register map, field layout and timing constants for the event interrupt unit
package peiu_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_EVENT_STATUS_0 = 8'h05; // Latched events, write one to clear
    localparam logic [7:0] ADDR_EVENT_MASK_0 = 8'h06; // Masks for first status register
    localparam logic [7:0] ADDR_EVENT_LIVE_0 = 8'h07; // Live levels of first group
    localparam logic [7:0] ADDR_FAULT_STATUS_1 = 8'h08; // Latched overcurrent events
    localparam logic [7:0] ADDR_FAULT_MASK_1 = 8'h09; // Overcurrent masks
    localparam logic [7:0] ADDR_FAULT_LIVE_1 = 8'h0A; // Live overcurrent levels
    localparam logic [7:0] ADDR_FUSE_STATUS_3 = 8'h0E; // Latched fuse error event
    localparam logic [7:0] ADDR_FUSE_MASK_3 = 8'h0F; // Fuse error mask
    localparam logic [7:0] ADDR_FUSE_LIVE_3 = 8'h10; // Live fuse error level

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int GRP0_W = 6; // Button, undervolt, four thermal bits
    localparam int GRP1_W = 7; // Seven regulator overcurrent bits
    localparam int FUSE_BIT = 7; // Fuse error bit position
    localparam int SUPPLY_BIT = 7; // Fuse supply level bit in first live register
    localparam int NSRC = 14; // Number of debounced sources
    localparam int SRC_BUTTON = 0; // Source index of the button
    localparam int SRC_UNDERVOLT = 1; // Source index of low input voltage
    localparam int SRC_HOT_LO = 2; // First thermal source index
    localparam int SRC_HOT_HI = 5; // Last thermal source index
    localparam int SRC_BUCK_LO = 6; // First overcurrent source index
    localparam int SRC_FUSE = 13; // Source index of fuse error
    localparam int CNT_W = 26; // Debounce counter width, holds eight button periods

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [GRP0_W-1:0] MASK0_RST = 6'h3F; // All masked at power-up
    localparam logic [GRP1_W-1:0] MASK1_RST = 7'h7F; // All masked at power-up

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250; // System clock rate in MHz
    localparam int DEB_SHORT_US = 3900; // Undervolt and thermal debounce, 3.9 ms
    localparam int DEB_BUTTON_US = 31250; // Button debounce, 31.25 ms
    localparam int DEB_FAULT_US = 8000; // Overcurrent and fuse debounce, 8.0 ms
    localparam int DEB_SHORT_CYC = DEB_SHORT_US * CLK_MHZ; // Cycles for short debounce
    localparam int DEB_BUTTON_CYC = DEB_BUTTON_US * CLK_MHZ; // Cycles for button debounce
    localparam int DEB_FAULT_CYC = DEB_FAULT_US * CLK_MHZ; // Cycles for fault debounce

    // ------------------------------------------------------------
    // Register request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr; // One-cycle write strobe
        logic rd; // One-cycle read strobe
        logic [7:0] addr; // Register offset
        logic [7:0] wdata; // Write data
    } peiu_req_t;

endpackage

// *** verilog/peiu_top.sv ***
// Event latching, masking, debouncing and interrupt pin logic of the power-management device
// Overview of operation
// - Pin low when any unmasked status set
// - Status latches on event, holds until cleared
// - Writing one clears status, pin may rise
// - Pin low until all cleared or masked
// - New event during clear is kept
// - Mask one blocks pin, status still latches
// - Masked status bits remain readable
// - All masks are one after reset
// - Unmasking set status drives pin low
// - Live bits show raw state, read-only
// - Event only after stable whole debounce period
// - Undervolt: falling supply, 3.9 ms debounce
// - Button: both edges, 31.25 ms debounce
// - Button falling debounce extended by select
// - Four thermal sources, both edges, 3.9 ms
// - Overcurrent: rising, 8.0 ms debounce
// - Fuse error: rising, 8.0 ms, live bit
// - First status: button, undervolt, thermal order
// - Second status: seven regulators bits 0-6
// - First live register mirrors, bit 7 supply
`timescale 1ns/1ps

module peiu_top #(
    parameter int DEB_SHORT = peiu_pkg::DEB_SHORT_CYC,
    parameter int DEB_BUTTON = peiu_pkg::DEB_BUTTON_CYC,
    parameter int DEB_FAULT = peiu_pkg::DEB_FAULT_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Register access from the serial port slave
    input wire peiu_pkg::peiu_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Event sources, synchronous to clk_sys
    input wire logic button_input,
    input wire logic [1:0] button_filter_sel,
    input wire logic undervolt_raw,
    input wire logic [3:0] hot_raw,
    input wire logic [6:0] buck_oc_raw,
    input wire logic fuse_err_raw,
    input wire logic fuse_prog_supply,
    // Interrupt pin to host
    output logic irq_out_n
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [peiu_pkg::GRP0_W-1:0] stat0; // Button, undervolt, thermal flags
        logic [peiu_pkg::GRP0_W-1:0] mask0; // Blocks for the above
        logic [peiu_pkg::GRP1_W-1:0] stat1; // Overcurrent flags
        logic [peiu_pkg::GRP1_W-1:0] mask1; // Overcurrent blocks
        logic fuse_flag; // Fuse error flag
        logic fuse_block; // Fuse error block
        logic [peiu_pkg::NSRC-1:0] stable; // Debounced level of each source
        logic [peiu_pkg::NSRC-1:0][peiu_pkg::CNT_W-1:0] cnt; // Debounce counters
        logic irq_n; // Registered interrupt pin
        logic [7:0] rdata; // Registered read data
    } peiu_state_t;

    peiu_state_t st_reg; // Current state
    peiu_state_t st_next; // Next state
    logic [peiu_pkg::NSRC-1:0] raw; // Source levels gathered by index
    logic [peiu_pkg::NSRC-1:0] evt; // One-cycle debounced events
    logic [peiu_pkg::GRP0_W-1:0] clr0; // Write-one-clear pattern, group 0
    logic [peiu_pkg::GRP1_W-1:0] clr1; // Write-one-clear pattern, group 1
    logic clr3; // Write-one-clear of fuse flag
    logic [7:0] live0; // First live register image
    logic [7:0] live1; // Second live register image
    logic [7:0] live3; // Fuse live register image

    // ------------------------------------------------------------
    // Debounce length per source and direction
    // ------------------------------------------------------------
    function automatic logic [peiu_pkg::CNT_W-1:0] deb_len(input int idx, input logic lvl,
                                                        input logic [1:0] sel);
        logic [peiu_pkg::CNT_W-1:0] len;
        len = peiu_pkg::CNT_W'(DEB_FAULT);
        if (idx == peiu_pkg::SRC_BUTTON) begin
            len = peiu_pkg::CNT_W'(DEB_BUTTON);
            if (!lvl) begin
                len = len << sel;
            end
        end else if (idx <= peiu_pkg::SRC_HOT_HI) begin
            len = peiu_pkg::CNT_W'(DEB_SHORT);
        end
        return len;
    endfunction

    // ------------------------------------------------------------
    // Which settled transition raises an event
    // ------------------------------------------------------------
    function automatic logic deb_fires(input int idx, input logic lvl);
        logic fire;
        fire = lvl; // Rising only for undervolt, overcurrent, fuse
        if (idx == peiu_pkg::SRC_BUTTON) begin
            fire = 1'b1; // Both edges
        end else if (idx >= peiu_pkg::SRC_HOT_LO && idx <= peiu_pkg::SRC_HOT_HI) begin
            fire = 1'b1; // Both crossings
        end
        return fire;
    endfunction

    // ------------------------------------------------------------
    // Source gathering and live images
    // ------------------------------------------------------------
    // Undervolt raw is high while input supply is at or below its threshold
    assign raw = {fuse_err_raw, buck_oc_raw, hot_raw, undervolt_raw, button_input};
    assign live0 = {fuse_prog_supply, 1'b0, hot_raw, undervolt_raw, button_input};
    assign live1 = {1'b0, buck_oc_raw};
    assign live3 = {fuse_err_raw, 7'h00};

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        evt = '0;
        // Debounce: a source must differ from its settled level for a whole period
        for (int i = 0; i < peiu_pkg::NSRC; i++) begin
            if (raw[i] == st_reg.stable[i]) begin
                st_next.cnt[i] = '0;
            end else if (st_reg.cnt[i] >= deb_len(i, raw[i], button_filter_sel)
                         - peiu_pkg::CNT_W'(1)) begin
                st_next.stable[i] = raw[i];
                st_next.cnt[i] = '0;
                evt[i] = deb_fires(i, raw[i]);
            end else begin
                st_next.cnt[i] = st_reg.cnt[i] + peiu_pkg::CNT_W'(1);
            end
        end
        // Write-one-clear decode; only defined bits can be cleared
        clr0 = '0;
        clr1 = '0;
        clr3 = 1'b0;
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                peiu_pkg::ADDR_EVENT_STATUS_0: begin
                    clr0 = reg_req.wdata[peiu_pkg::GRP0_W-1:0];
                end
                peiu_pkg::ADDR_FAULT_STATUS_1: begin
                    clr1 = reg_req.wdata[peiu_pkg::GRP1_W-1:0];
                end
                peiu_pkg::ADDR_FUSE_STATUS_3: begin
                    clr3 = reg_req.wdata[peiu_pkg::FUSE_BIT];
                end
                peiu_pkg::ADDR_EVENT_MASK_0: begin
                    st_next.mask0 = reg_req.wdata[peiu_pkg::GRP0_W-1:0];
                end
                peiu_pkg::ADDR_FAULT_MASK_1: begin
                    st_next.mask1 = reg_req.wdata[peiu_pkg::GRP1_W-1:0];
                end
                peiu_pkg::ADDR_FUSE_MASK_3: begin
                    st_next.fuse_block = reg_req.wdata[peiu_pkg::FUSE_BIT];
                end
                default: begin
                    // Live and unmapped offsets ignore writes
                end
            endcase
        end
        // Latch: a new event wins over a clear in the same cycle
        st_next.stat0 = (st_reg.stat0 & ~clr0)
                        | evt[peiu_pkg::SRC_HOT_HI:peiu_pkg::SRC_BUTTON];
        st_next.stat1 = (st_reg.stat1 & ~clr1)
                        | evt[peiu_pkg::SRC_FUSE-1:peiu_pkg::SRC_BUCK_LO];
        st_next.fuse_flag = (st_reg.fuse_flag & ~clr3) | evt[peiu_pkg::SRC_FUSE];
        // Pin follows the new flags and masks at the same edge
        st_next.irq_n = ~(|(st_next.stat0 & ~st_next.mask0)
                          | |(st_next.stat1 & ~st_next.mask1)
                          | (st_next.fuse_flag & ~st_next.fuse_block));
        // Read mux, registered; unmapped offsets read zero
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                peiu_pkg::ADDR_EVENT_STATUS_0: begin
                    st_next.rdata = {2'b00, st_reg.stat0};
                end
                peiu_pkg::ADDR_EVENT_MASK_0: begin
                    st_next.rdata = {2'b00, st_reg.mask0};
                end
                peiu_pkg::ADDR_EVENT_LIVE_0: begin
                    st_next.rdata = live0;
                end
                peiu_pkg::ADDR_FAULT_STATUS_1: begin
                    st_next.rdata = {1'b0, st_reg.stat1};
                end
                peiu_pkg::ADDR_FAULT_MASK_1: begin
                    st_next.rdata = {1'b0, st_reg.mask1};
                end
                peiu_pkg::ADDR_FAULT_LIVE_1: begin
                    st_next.rdata = live1;
                end
                peiu_pkg::ADDR_FUSE_STATUS_3: begin
                    st_next.rdata = {st_reg.fuse_flag, 7'h00};
                end
                peiu_pkg::ADDR_FUSE_MASK_3: begin
                    st_next.rdata = {st_reg.fuse_block, 7'h00};
                end
                peiu_pkg::ADDR_FUSE_LIVE_3: begin
                    st_next.rdata = live3;
                end
                default: begin
                    st_next.rdata = 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg <= '0;
            st_reg.mask0 <= peiu_pkg::MASK0_RST;
            st_reg.mask1 <= peiu_pkg::MASK1_RST;
            st_reg.fuse_block <= 1'b1;
            st_reg.irq_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flip-flops
    assign irq_out_n = st_reg.irq_n;
    assign reg_rdata = st_reg.rdata;

endmodule

// *** sim/peiu_assertions.sv ***
// Port-level checker of the event interrupt unit
`timescale 1ns/1ps

module peiu_assertions (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Register port
    input wire peiu_pkg::peiu_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    // Raw sources
    input wire logic button_input,
    input wire logic undervolt_raw,
    input wire logic [3:0] hot_raw,
    input wire logic [6:0] buck_oc_raw,
    input wire logic fuse_err_raw,
    input wire logic fuse_prog_supply,
    // Interrupt pin
    input wire logic irq_out_n
);
    // ------------------------------------------------------------
    // Mask mirror rebuilt from writes seen on the port
    // ------------------------------------------------------------
    logic [13:0] msk_reg; // Fuse, group one and group zero masks
    always_ff @(posedge clk_sys) begin
        if (srst)
            msk_reg <= 14'h3FFF;
        else if (reg_req.wr && reg_req.addr == 8'h06)
            msk_reg[5:0] <= reg_req.wdata[5:0];
        else if (reg_req.wr && reg_req.addr == 8'h09)
            msk_reg[12:6] <= reg_req.wdata[6:0];
        else if (reg_req.wr && reg_req.addr == 8'h0F)
            msk_reg[13] <= reg_req.wdata[7];
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Read request of one offset
    sequence rd_at(logic [7:0] a);
        reg_req.rd && reg_req.addr == a;
    endsequence
    reset_state_a: assert property ($fell(srst) |-> irq_out_n && reg_rdata == 8'h00)
        else $error("reset left pin low or read data set");
    masked_quiet_a: assert property (&msk_reg |-> irq_out_n)
        else $error("pin low while every source is masked");
    rise_by_write_a: assert property ($rose(irq_out_n) && !$past(srst) |-> $past(reg_req.wr))
        else $error("pin rose without a host write");
    live0_read_a: assert property (rd_at(8'h07) |=>
        reg_rdata == {$past(fuse_prog_supply), 1'b0, $past(hot_raw), $past(undervolt_raw),
        $past(button_input)}) else $error("live group zero read wrong");
    live1_read_a: assert property (rd_at(8'h0A) |=> reg_rdata == {1'b0, $past(buck_oc_raw)})
        else $error("live overcurrent read wrong");
    fuse_live_a: assert property (rd_at(8'h10) |=> reg_rdata == {$past(fuse_err_raw), 7'h00})
        else $error("live fuse read wrong");
    unmapped_rd_a: assert property (reg_req.rd && !(reg_req.addr inside {[8'h05:8'h0A],
        [8'h0E:8'h10]}) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    unused_zero_a: assert property (rd_at(8'h05) or rd_at(8'h06) |=> reg_rdata[7:6] == 2'b00)
        else $error("unused bits read nonzero");
    rdata_hold_a: assert property (!reg_req.rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule

// *** sim/peiu_host_model.sv ***
// Host processor model that reaches the registers through the request port
`timescale 1ns/1ps

module peiu_host_model (
    // Clock
    input wire logic clk_sys,
    // Register port
    output peiu_pkg::peiu_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    // Idle port at time zero
    initial begin
        reg_req = '0;
    end
    // One-cycle write; address and data are scrambled once released
    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk_sys);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask
    // One-cycle read; the registered answer is taken one edge later
    task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_sys);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'hA5};
        @(posedge clk_sys);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'h5A};
        @(posedge clk_sys);
        data = reg_rdata;
    endtask
endmodule

// *** sim/peiu_top_tb_top.sv ***
// Self-checking bench of the event interrupt unit
`timescale 1ns/1ps

module peiu_top_tb_top;
    // Design signals
    logic clk_sys, srst, button_input, undervolt_raw, fuse_err_raw, fuse_prog_supply, irq_out_n;
    logic [1:0] button_filter_sel;
    logic [3:0] hot_raw;
    logic [6:0] buck_oc_raw;
    logic [7:0] reg_rdata, rv;
    peiu_pkg::peiu_req_t reg_req;
    int err_count, n_checks;
    // Reset table: offsets and expected values
    logic [7:0] ra [9] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0E, 8'h0F, 8'h0B, 8'h20};
    logic [7:0] re [9] = '{8'h00, 8'h3F, 8'h80, 8'h00, 8'h7F, 8'h00, 8'h80, 8'h00, 8'h00};
    // Short debounce counts keep the run brief
    peiu_top #(.DEB_SHORT(8), .DEB_BUTTON(16), .DEB_FAULT(12)) dut (.clk_sys, .srst, .reg_req,
        .reg_rdata, .button_input, .button_filter_sel, .undervolt_raw, .hot_raw, .buck_oc_raw,
        .fuse_err_raw, .fuse_prog_supply, .irq_out_n);
    peiu_host_model u_host (.clk_sys, .reg_req, .reg_rdata);
    // Comparison with report
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Register read and compare
    task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
        u_host.rd_reg(addr, rv);
        check($sformatf("reg %h", addr), rv, exp);
    endtask
    // Pin compare after the last write has landed
    task automatic irqchk(input logic exp);
        @(posedge clk_sys);
        check("irq_out_n", {7'h00, irq_out_n}, {7'h00, exp});
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Verdict and end of run
    task automatic final_report;
        if (err_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Clock of 4 ns
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Watchdog against a hang
    initial begin
        wait_cyc(5000);
        err_count++;
        final_report();
    end
    // Main sequence
    initial begin
        srst = 1'b1; button_input = 1'b0; button_filter_sel = 2'd0; undervolt_raw = 1'b0;
        hot_raw = 4'h0; buck_oc_raw = 7'h00; fuse_err_raw = 1'b0; fuse_prog_supply = 1'b1;
        err_count = 0; n_checks = 0;
        wait_cyc(4);
        srst <= 1'b0;
        for (int i = 0; i < 9; i++) rchk(ra[i], re[i]);
        u_host.wr_reg(8'h07, 8'h00); rchk(8'h07, 8'h80);
        u_host.wr_reg(8'h06, 8'hFF); rchk(8'h06, 8'h3F);
        // Thermal sources: glitch, both crossings, masked pin
        for (int k = 0; k < 4; k++) begin
            hot_raw[k] <= 1'b1; wait_cyc(7); hot_raw[k] <= 1'b0; wait_cyc(12);
            rchk(8'h05, 8'h00);
            hot_raw[k] <= 1'b1; wait_cyc(12);
            rchk(8'h05, 8'h04 << k);
            irqchk(1'b1);
            u_host.wr_reg(8'h05, 8'h04 << k); rchk(8'h05, 8'h00);
            hot_raw[k] <= 1'b0; wait_cyc(12);
            rchk(8'h05, 8'h04 << k);
            u_host.wr_reg(8'h05, 8'hFF);
        end
        // Undervolt: rising sets, falling only settles
        undervolt_raw <= 1'b1; wait_cyc(12); rchk(8'h05, 8'h02);
        u_host.wr_reg(8'h05, 8'h02); undervolt_raw <= 1'b0; wait_cyc(12);
        rchk(8'h05, 8'h00);
        // Button: rising at base period, falling stretched fourfold by select 2
        button_input <= 1'b1; wait_cyc(20); rchk(8'h05, 8'h01);
        rchk(8'h07, 8'h81);
        u_host.wr_reg(8'h05, 8'h01); button_filter_sel <= 2'd2; button_input <= 1'b0;
        wait_cyc(40); rchk(8'h05, 8'h00);
        wait_cyc(30); rchk(8'h05, 8'h01);
        u_host.wr_reg(8'h05, 8'h01);
        // Overcurrent: each regulator in turn, falling edge must not set
        for (int k = 0; k < 7; k++) begin
            buck_oc_raw <= 7'h01 << k; wait_cyc(14);
            rchk(8'h08, 8'h01 << k);
            u_host.wr_reg(8'h08, 8'h01 << k); buck_oc_raw <= 7'h00; wait_cyc(14);
        end
        rchk(8'h08, 8'h00);
        fuse_err_raw <= 1'b1; wait_cyc(14); rchk(8'h0E, 8'h80);
        u_host.wr_reg(8'h0E, 8'h80); rchk(8'h0E, 8'h00);
        // Pin: masked poll, unmask, partial clear, remask, set during clear
        buck_oc_raw <= 7'h03; wait_cyc(14); irqchk(1'b1);
        rchk(8'h08, 8'h03);
        u_host.wr_reg(8'h09, 8'h7C); irqchk(1'b0);
        u_host.wr_reg(8'h08, 8'h01); irqchk(1'b0);
        u_host.wr_reg(8'h09, 8'h7E); irqchk(1'b1);
        u_host.wr_reg(8'h09, 8'h78); irqchk(1'b0);
        buck_oc_raw <= 7'h07; wait_cyc(10);
        u_host.wr_reg(8'h08, 8'h02); irqchk(1'b0);
        rchk(8'h08, 8'h04);
        u_host.wr_reg(8'h08, 8'h04); irqchk(1'b1);
        // Second reset in mid-run
        srst <= 1'b1; wait_cyc(2); srst <= 1'b0;
        rchk(8'h09, 8'h7F);
        final_report();
    end
endmodule

bind peiu_top peiu_assertions u_chk (.clk_sys, .srst, .reg_req, .reg_rdata, .button_input,
    .undervolt_raw, .hot_raw, .buck_oc_raw, .fuse_err_raw, .fuse_prog_supply, .irq_out_n);
